// ### rtl/mtd_pkg.sv
// shared constants and types for the mains time difference configuration block
package mtd_pkg;

  // parameter byte geometry and reset values
  localparam int PARAM_W = 8;
  localparam logic [7:0] SECOND_PORT_RESET = 8'h00;
  localparam logic [7:0] NOMINAL_FREQ_RESET = 8'h00;
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam int FREQ_SEL_BIT = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // entry targets chosen by the operator when an entry opens
  localparam logic [1:0] TGT_SECOND_PORT = 2'h0;
  localparam logic [1:0] TGT_NOMINAL_FREQ = 2'h1;
  localparam logic [1:0] TGT_SPARE = 2'h2;
  localparam logic [1:0] TGT_TIME_DIFF = 2'h3;

  // mains time difference: sign, two second digits, three millisecond digits
  localparam int DIFF_W = 18;
  localparam int DIFF_MAG_W = 17;
  localparam int SEC_W = 7;
  localparam int MSEC_W = 10;
  localparam logic [2:0] SEC_DIGITS = 3'h2;
  localparam logic [2:0] DIFF_DIGITS = 3'h5;
  localparam logic [9:0] MS_PER_SEC = 10'h3e8;
  localparam logic [16:0] DIFF_MAX_MS = 17'h1869f;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [DIFF_W-1:0] DIFF_RESET = 18'h00000;

  // time of day in milliseconds and measured frequency in millihertz
  localparam int TIME_W = 27;
  localparam logic [TIME_W-1:0] DAY_MS = 27'h5265c00;
  localparam int FREQ_W = 17;

  // operator entry sequencer, gray coded along idle -> bits -> digits
  typedef enum logic [1:0] {
    MTD_IDLE = 2'b00,
    MTD_BITS = 2'b01,
    MTD_DIGITS = 2'b11
  } mtd_state_t;

endpackage

// ### rtl/mtd_clear_sync.sv
// synchroniser and falling-edge detector for the external clear pulse
`timescale 1ns/1ps
module mtd_clear_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw pulse from the isolated input
  input wire logic pulse_in,
  // one-cycle clear request
  output logic fall_out
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two-stage synchroniser; stages reset high so no edge is seen at release
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= pulse_in;
      sync_reg <= meta_reg;
    end
  end

  // edge detector looks only at the settled stage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_reg <= 1'b1;
      fall_out <= 1'b0;
    end
    else
    begin
      last_reg <= sync_reg;
      fall_out <= last_reg & ~sync_reg;
    end
  end

endmodule // mtd_clear_sync

// ### rtl/mtd_config.sv
// parameter bytes and mains time difference with keypad entry and readback
`timescale 1ns/1ps

// Summary of operation
// - second serial port byte is stored but none of its bits acts.
// - nominal frequency byte bit 0 selects 50 Hz when 0, 60 Hz when 1.
// - spare byte is stored and ignored entirely.
// - a byte is entered whole, bit 7 first, and applied only on confirm.
// - a signed time difference from -99.999 s to +99.999 s is accepted.
// - zero entered with either sign is stored as zero, applied on confirm.
// - falling edge on the clear pulse input zeroes the time difference.
// - reset or power loss leaves the time difference at positive zero.
// - mains time, signed difference, frequency and system time are read back.
module mtd_config
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // keypad entry
  input wire logic entry_start,
  input wire logic [1:0] entry_target,
  input wire logic entry_cancel,
  input wire logic bit_strobe,
  input wire logic bit_value,
  input wire logic sign_strobe,
  input wire logic sign_minus,
  input wire logic digit_strobe,
  input wire logic [3:0] digit_value,
  input wire logic confirm_key,
  // external clear pulse, falling edge active
  input wire logic clear_pulse_in,
  // measurements supplied by the analysis logic
  input wire logic [mtd_pkg::TIME_W-1:0] system_time_in,
  input wire logic [mtd_pkg::FREQ_W-1:0] mains_freq_in,
  // parameter bytes and decoded setting
  output logic [7:0] second_serial_port_reg,
  output logic [7:0] nominal_frequency_reg,
  output logic [7:0] spare_reg,
  output logic nominal_60hz_reg,
  // time difference readback
  output logic signed [mtd_pkg::DIFF_W-1:0] diff_ms_reg,
  output logic diff_negative_reg,
  output logic [mtd_pkg::SEC_W-1:0] diff_sec_reg,
  output logic [mtd_pkg::MSEC_W-1:0] diff_msec_reg,
  // measurement readback
  output logic [mtd_pkg::TIME_W-1:0] mains_time_field_reg,
  output logic [mtd_pkg::TIME_W-1:0] system_time_field_reg,
  output logic [mtd_pkg::FREQ_W-1:0] mains_freq_reg,
  // entry status
  output logic entry_busy_reg,
  output logic entry_done_reg,
  output logic entry_error_reg
);

  mtd_pkg::mtd_state_t state_reg;
  mtd_pkg::mtd_state_t state_next;
  logic [1:0] target_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic sign_seen_reg;
  logic sign_neg_reg;
  logic [2:0] dig_cnt_reg;
  logic [mtd_pkg::SEC_W-1:0] sec_acc_reg;
  logic [mtd_pkg::MSEC_W-1:0] ms_acc_reg;
  logic bad_entry_reg;
  logic clear_fall;
  logic bits_ok;
  logic digits_ok;
  logic apply_bits;
  logic apply_diff;
  logic reject;
  logic [mtd_pkg::DIFF_MAG_W-1:0] entry_mag;
  logic entry_neg;
  logic signed [mtd_pkg::DIFF_W-1:0] entry_ms;
  logic signed [28:0] mt_sum;
  logic [mtd_pkg::TIME_W-1:0] mt_wrapped;

  // decimal accumulate step shared by the second and millisecond fields
  function automatic logic [mtd_pkg::MSEC_W-1:0] dec_push(
    input logic [mtd_pkg::MSEC_W-1:0] acc,
    input logic [3:0] digit
  );
    logic [13:0] wide;
    wide = 14'(acc) * 14'h00a + 14'(digit);
    return wide[mtd_pkg::MSEC_W-1:0];
  endfunction

  // clear pulse crossing into the clock domain
  mtd_clear_sync u_clear_sync
  (
    .clk(clk),
    .nrst(nrst),
    .pulse_in(clear_pulse_in),
    .fall_out(clear_fall)
  );

  // completeness checks made at the moment of confirmation
  assign bits_ok = (bit_cnt_reg == mtd_pkg::BITS_PER_BYTE);
  assign digits_ok = sign_seen_reg && !bad_entry_reg
    && (dig_cnt_reg == mtd_pkg::DIFF_DIGITS);
  assign apply_bits = (state_reg == mtd_pkg::MTD_BITS) && confirm_key && bits_ok;
  assign apply_diff = (state_reg == mtd_pkg::MTD_DIGITS) && confirm_key && digits_ok;
  assign reject = confirm_key && (((state_reg == mtd_pkg::MTD_BITS) && !bits_ok)
    || ((state_reg == mtd_pkg::MTD_DIGITS) && !digits_ok));

  // entered magnitude in milliseconds; a zero magnitude forces a plus sign
  always_comb
  begin
    entry_mag = 17'(sec_acc_reg) * 17'(mtd_pkg::MS_PER_SEC) + 17'(ms_acc_reg);
    entry_neg = sign_neg_reg && (entry_mag != 17'h00000);
    if (entry_neg)
    begin
      entry_ms = -$signed({1'b0, entry_mag});
    end
    else
    begin
      entry_ms = $signed({1'b0, entry_mag});
    end
  end

  // entry sequencer: a new start always restarts, cancel or confirm ends it
  always_comb
  begin
    state_next = state_reg;
    if (entry_start)
    begin
      if (entry_target == mtd_pkg::TGT_TIME_DIFF)
      begin
        state_next = mtd_pkg::MTD_DIGITS;
      end
      else
      begin
        state_next = mtd_pkg::MTD_BITS;
      end
    end
    else if (entry_cancel || confirm_key)
    begin
      state_next = mtd_pkg::MTD_IDLE;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= mtd_pkg::MTD_IDLE;
      target_reg <= mtd_pkg::TGT_SECOND_PORT;
    end
    else
    begin
      state_reg <= state_next;
      if (entry_start)
      begin
        target_reg <= entry_target;
      end
    end
  end

  // bit collection, most significant bit arrives first
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end
    else if (entry_start)
    begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end
    else if ((state_reg == mtd_pkg::MTD_BITS) && bit_strobe)
    begin
      shift_reg <= {shift_reg[6:0], bit_value};
      if (bit_cnt_reg <= mtd_pkg::BITS_PER_BYTE)
      begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1; // a ninth bit spoils the entry
      end
    end
  end

  // sign and digit collection for the time difference
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sign_seen_reg <= 1'b0;
      sign_neg_reg <= 1'b0;
      dig_cnt_reg <= 3'h0;
      sec_acc_reg <= 7'h00;
      ms_acc_reg <= 10'h000;
      bad_entry_reg <= 1'b0;
    end
    else if (entry_start)
    begin
      sign_seen_reg <= 1'b0;
      sign_neg_reg <= 1'b0;
      dig_cnt_reg <= 3'h0;
      sec_acc_reg <= 7'h00;
      ms_acc_reg <= 10'h000;
      bad_entry_reg <= 1'b0;
    end
    else if (state_reg == mtd_pkg::MTD_DIGITS)
    begin
      if (sign_strobe)
      begin
        // sign must lead the digits; a late sign spoils the entry
        sign_seen_reg <= 1'b1;
        sign_neg_reg <= sign_minus;
        if (dig_cnt_reg != 3'h0)
        begin
          bad_entry_reg <= 1'b1;
        end
      end
      else if (digit_strobe)
      begin
        if ((digit_value > mtd_pkg::DIGIT_MAX) || (dig_cnt_reg == mtd_pkg::DIFF_DIGITS))
        begin
          bad_entry_reg <= 1'b1;
        end
        else
        begin
          dig_cnt_reg <= dig_cnt_reg + 3'h1;
          if (dig_cnt_reg < mtd_pkg::SEC_DIGITS)
          begin
            sec_acc_reg <= 7'(dec_push(10'(sec_acc_reg), digit_value));
          end
          else
          begin
            ms_acc_reg <= dec_push(ms_acc_reg, digit_value);
          end
        end
      end
    end
  end

  // parameter bytes: only a complete, confirmed byte is written
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      second_serial_port_reg <= mtd_pkg::SECOND_PORT_RESET;
      nominal_frequency_reg <= mtd_pkg::NOMINAL_FREQ_RESET;
      spare_reg <= mtd_pkg::SPARE_RESET;
    end
    else if (apply_bits)
    begin
      unique case (target_reg)
        mtd_pkg::TGT_SECOND_PORT: second_serial_port_reg <= shift_reg;
        mtd_pkg::TGT_NOMINAL_FREQ: nominal_frequency_reg <= shift_reg;
        mtd_pkg::TGT_SPARE: spare_reg <= shift_reg;
        mtd_pkg::TGT_TIME_DIFF: spare_reg <= spare_reg;
      endcase
    end
  end

  // only bit 0 of the nominal frequency byte steers anything
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nominal_60hz_reg <= mtd_pkg::NOMINAL_FREQ_RESET[mtd_pkg::FREQ_SEL_BIT];
    end
    else
    begin
      nominal_60hz_reg <= nominal_frequency_reg[mtd_pkg::FREQ_SEL_BIT];
    end
  end

  // stored difference; the external clear outranks an operator confirm
  // in the same cycle because it is the synchronising event
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      diff_ms_reg <= mtd_pkg::DIFF_RESET;
      diff_negative_reg <= 1'b0;
      diff_sec_reg <= 7'h00;
      diff_msec_reg <= 10'h000;
    end
    else if (clear_fall)
    begin
      diff_ms_reg <= mtd_pkg::DIFF_RESET;
      diff_negative_reg <= 1'b0;
      diff_sec_reg <= 7'h00;
      diff_msec_reg <= 10'h000;
    end
    else if (apply_diff && (entry_mag <= mtd_pkg::DIFF_MAX_MS))
    begin
      diff_ms_reg <= entry_ms;
      diff_negative_reg <= entry_neg;
      diff_sec_reg <= sec_acc_reg;
      diff_msec_reg <= ms_acc_reg;
    end
  end

  // mains time = system time plus difference, wrapped into one day;
  // the difference is far below a day so one correction is enough
  always_comb
  begin
    mt_sum = $signed({2'b00, system_time_in}) + 29'(diff_ms_reg);
    if (mt_sum < 29'sd0)
    begin
      mt_wrapped = 27'(mt_sum + $signed({2'b00, mtd_pkg::DAY_MS}));
    end
    else if (mt_sum >= $signed({2'b00, mtd_pkg::DAY_MS}))
    begin
      mt_wrapped = 27'(mt_sum - $signed({2'b00, mtd_pkg::DAY_MS}));
    end
    else
    begin
      mt_wrapped = mt_sum[mtd_pkg::TIME_W-1:0];
    end
  end

  // readback fields, registered so all outputs come from flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mains_time_field_reg <= 27'h0000000;
      system_time_field_reg <= 27'h0000000;
      mains_freq_reg <= 17'h00000;
    end
    else
    begin
      mains_time_field_reg <= mt_wrapped;
      system_time_field_reg <= system_time_in;
      mains_freq_reg <= mains_freq_in;
    end
  end

  // entry status: busy level, done and error one-cycle pulses
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      entry_busy_reg <= 1'b0;
      entry_done_reg <= 1'b0;
      entry_error_reg <= 1'b0;
    end
    else
    begin
      entry_busy_reg <= (state_next != mtd_pkg::MTD_IDLE);
      entry_done_reg <= apply_bits || apply_diff;
      entry_error_reg <= reject;
    end
  end

endmodule // mtd_config

// ### test/mtd_config_checker.sv
// port assertions for the mains time difference block
`timescale 1ns/1ps
module mtd_config_checker
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // stimulus seen at the ports
  input wire logic entry_start,
  input wire logic confirm_key,
  input wire logic clear_pulse_in,
  // outputs watched
  input wire logic [7:0] second_serial_port_reg,
  input wire logic [7:0] nominal_frequency_reg,
  input wire logic [7:0] spare_reg,
  input wire logic nominal_60hz_reg,
  input wire logic signed [mtd_pkg::DIFF_W-1:0] diff_ms_reg,
  input wire logic diff_negative_reg,
  input wire logic [mtd_pkg::SEC_W-1:0] diff_sec_reg,
  input wire logic [mtd_pkg::MSEC_W-1:0] diff_msec_reg,
  input wire logic entry_busy_reg,
  input wire logic entry_done_reg,
  input wire logic entry_error_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // bytes move only on a confirm, so a cancelled entry cannot write
  chk_param_on_confirm: assert property (
    !$stable({second_serial_port_reg, nominal_frequency_reg, spare_reg}) |-> $past(confirm_key))
    else $error("parameter byte changed without confirm");
  chk_done_source: assert property (
    entry_done_reg |-> $past(confirm_key) && $past(entry_busy_reg))
    else $error("done without confirm of an open entry");
  chk_start_busy: assert property (entry_start |=> entry_busy_reg)
    else $error("entry not open after start");
  chk_done_excl: assert property (!(entry_done_reg && entry_error_reg))
    else $error("done and error together");
  chk_freq_select: assert property (
    nominal_60hz_reg == $past(nominal_frequency_reg[0]))
    else $error("frequency select does not follow bit 0");
  chk_diff_range: assert property (
    diff_ms_reg <= 18'sd99999 && diff_ms_reg >= -18'sd99999)
    else $error("difference out of range");
  // split fields must agree with the signed count; minus zero shows as plus
  chk_sign_magnitude: assert property (
    diff_negative_reg == (diff_ms_reg < 0) && int'(diff_sec_reg) * 1000 + int'(diff_msec_reg)
    == ((diff_ms_reg < 0) ? -int'(diff_ms_reg) : int'(diff_ms_reg)))
    else $error("sign or seconds split wrong");
  chk_clear_zero: assert property ($fell(clear_pulse_in) |-> ##4 diff_ms_reg == 0)
    else $error("clear edge did not zero difference");
  chk_diff_cause: assert property (
    !$stable(diff_ms_reg) |-> $past(confirm_key)
    || ($past(clear_pulse_in, 5) && !$past(clear_pulse_in, 4)))
    else $error("difference changed without cause");
  chk_reset_zero: assert property (
    !$past(nrst) |-> diff_ms_reg == 0 && !diff_negative_reg && nominal_frequency_reg == 0)
    else $error("state not cleared by reset");
  cov_done: cover property (entry_done_reg);
  cov_error: cover property (entry_error_reg);
  cov_clear: cover property ($fell(clear_pulse_in));
  cov_negative: cover property (diff_negative_reg);
endmodule // mtd_config_checker

bind mtd_config mtd_config_checker u_chk (.clk(clk), .nrst(nrst), .entry_start(entry_start),
  .confirm_key(confirm_key), .clear_pulse_in(clear_pulse_in),
  .second_serial_port_reg(second_serial_port_reg), .nominal_frequency_reg(nominal_frequency_reg),
  .spare_reg(spare_reg), .nominal_60hz_reg(nominal_60hz_reg), .diff_ms_reg(diff_ms_reg),
  .diff_negative_reg(diff_negative_reg), .diff_sec_reg(diff_sec_reg),
  .diff_msec_reg(diff_msec_reg), .entry_busy_reg(entry_busy_reg),
  .entry_done_reg(entry_done_reg), .entry_error_reg(entry_error_reg));

// ### test/mtd_keypad_model.sv
// operator keypad and master clear-pulse source facing the block
`timescale 1ns/1ps
module mtd_keypad_model
(
  // clock
  input wire logic clk,
  // keypad lines
  output logic entry_start,
  output logic [1:0] entry_target,
  output logic entry_cancel,
  output logic bit_strobe,
  output logic bit_value,
  output logic sign_strobe,
  output logic sign_minus,
  output logic digit_strobe,
  output logic [3:0] digit_value,
  output logic confirm_key,
  // isolated clear input, idles high
  output logic clear_pulse_in
);
  initial
  begin
    {entry_start, entry_target, entry_cancel, bit_strobe, bit_value} = '0;
    {sign_strobe, sign_minus, digit_strobe, digit_value, confirm_key} = '0;
    clear_pulse_in = 1'b1;
  end
  // one action per cycle; unused qualifiers flip so a stale value never looks valid
  task automatic act(input logic [2:0] k, input logic [3:0] v);
    @(posedge clk);
    entry_start <= (k == 3'h1);
    entry_target <= (k == 3'h1) ? v[1:0] : ~entry_target;
    bit_strobe <= (k == 3'h2);
    bit_value <= (k == 3'h2) ? v[0] : ~bit_value;
    sign_strobe <= (k == 3'h3);
    sign_minus <= (k == 3'h3) ? v[0] : ~sign_minus;
    digit_strobe <= (k == 3'h4);
    digit_value <= (k == 3'h4) ? v : ~digit_value;
    confirm_key <= (k == 3'h5);
    entry_cancel <= (k == 3'h6);
  endtask
  // first n bits of the byte, bit 7 first, then confirm
  task automatic put_byte(input logic [1:0] t, input logic [7:0] b, input int n);
    act(3'h1, {2'h0, t});
    for (int i = 7; i > 7 - n; i--) act(3'h2, {3'h0, b[i]});
    act(3'h5, 4'h0);
    act(3'h0, 4'h0);
  endtask
  // sign first, then seconds and millisecond digits, then confirm
  task automatic put_diff(input logic m, input logic [19:0] d, input int n);
    act(3'h1, 4'h3);
    act(3'h3, {3'h0, m});
    for (int i = 0; i < n; i++) act(3'h4, d[19-4*i -: 4]);
    act(3'h5, 4'h0);
    act(3'h0, 4'h0);
  endtask
  task automatic cancel_byte();
    act(3'h1, 4'h1);
    act(3'h2, 4'h1);
    act(3'h6, 4'h0);
    act(3'h0, 4'h0);
  endtask
  // low for three cycles so the synchroniser sees each level at least twice
  task automatic clear();
    @(posedge clk);
    clear_pulse_in <= 1'b0;
    repeat (3) @(posedge clk);
    clear_pulse_in <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule // mtd_keypad_model

// ### test/testbench.sv
// self-checking bench for the mains time difference block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  // time one ms before midnight so a positive difference wraps
  logic [mtd_pkg::TIME_W-1:0] system_time_field = mtd_pkg::DAY_MS - 27'h1;
  logic [mtd_pkg::FREQ_W-1:0] freq = 17'h0c3a9;
  wire logic st, cc, bs, bv, ss, sm, ds, cf, clr;
  wire logic [1:0] tg;
  wire logic [3:0] dv;
  logic [7:0] p2, p3, p4;
  logic hz60, neg, busy, done, err;
  logic signed [mtd_pkg::DIFF_W-1:0] dms;
  logic [mtd_pkg::SEC_W-1:0] dsec;
  logic [mtd_pkg::MSEC_W-1:0] dmsec;
  logic [mtd_pkg::TIME_W-1:0] mtime, stime;
  logic [mtd_pkg::FREQ_W-1:0] mfreq;
  int err_count = 0;
  int compares = 0;
  always #50 clk = ~clk;
  mtd_keypad_model kp (.clk(clk), .entry_start(st), .entry_target(tg), .entry_cancel(cc),
    .bit_strobe(bs), .bit_value(bv), .sign_strobe(ss), .sign_minus(sm), .digit_strobe(ds),
    .digit_value(dv), .confirm_key(cf), .clear_pulse_in(clr));
  mtd_config dut (.clk(clk), .nrst(nrst), .entry_start(st), .entry_target(tg),
    .entry_cancel(cc), .bit_strobe(bs), .bit_value(bv), .sign_strobe(ss), .sign_minus(sm),
    .digit_strobe(ds), .digit_value(dv), .confirm_key(cf), .clear_pulse_in(clr),
    .system_time_in(system_time_field), .mains_freq_in(freq), .second_serial_port_reg(p2),
    .nominal_frequency_reg(p3), .spare_reg(p4), .nominal_60hz_reg(hz60), .diff_ms_reg(dms),
    .diff_negative_reg(neg), .diff_sec_reg(dsec), .diff_msec_reg(dmsec),
    .mains_time_field_reg(mtime), .system_time_field_reg(stime), .mains_freq_reg(mfreq),
    .entry_busy_reg(busy), .entry_done_reg(done), .entry_error_reg(err));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic run_byte(input logic [1:0] t, input logic [7:0] b, input int n,
    input logic ok, input logic [7:0] e);
    kp.put_byte(t, b, n);
    #1;
    cmp("done", ok, done);
    cmp("error", !ok, err);
    cmp("byte", e, (t == 2'h0) ? p2 : (t == 2'h1) ? p3 : p4);
    @(posedge clk);
    #1;
    if (t == 2'h1) cmp("freq_select", e[0], hz60);
    $display("test byte entry done");
  endtask
  task automatic run_diff(input logic m, input logic [19:0] d, input int n, input logic ok,
    input int e);
    int a;
    a = (e < 0) ? -e : e;
    kp.put_diff(m, d, n);
    #1;
    cmp("done", ok, done);
    cmp("error", !ok, err);
    cmp("diff", e, dms);
    cmp("negative", e < 0, neg);
    cmp("seconds", a / 1000, dsec);
    cmp("millis", a % 1000, dmsec);
    $display("test diff entry done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    cmp("second_port", 32'h0, p2);
    cmp("nominal", 32'h0, p3);
    cmp("spare", 32'h0, p4);
    cmp("diff", 32'h0, dms);
    $display("test reset done");
    run_byte(2'h0, 8'ha5, 8, 1'b1, 8'ha5);
    run_byte(2'h1, 8'h01, 8, 1'b1, 8'h01);
    run_byte(2'h2, 8'h5a, 8, 1'b1, 8'h5a);
    run_byte(2'h1, 8'hff, 7, 1'b0, 8'h01);
    run_byte(2'h1, 8'h80, 8, 1'b1, 8'h80);
    kp.cancel_byte();
    #1;
    cmp("busy", 32'h0, busy);
    cmp("nominal", 32'h80, p3);
    // a confirm with no entry open must neither write nor pulse
    kp.act(3'h5, 4'h0);
    kp.act(3'h0, 4'h0);
    #1;
    cmp("idle_done", 32'h0, done);
    cmp("idle_error", 32'h0, err);
    cmp("nominal", 32'h80, p3);
    $display("test cancel and idle confirm done");
    run_diff(1'b0, 20'h20930, 5, 1'b1, 20930);
    @(posedge clk);
    #1;
    cmp("mains_time", (int'(system_time_field) + 20930) % int'(mtd_pkg::DAY_MS), mtime);
    cmp("system_time", system_time_field, stime);
    cmp("frequency", freq, mfreq);
    kp.clear();
    #1;
    cmp("diff", 32'h0, dms);
    run_diff(1'b1, 20'h99999, 5, 1'b1, -99999);
    run_diff(1'b1, 20'h00000, 5, 1'b1, 0);
    run_diff(1'b0, 20'h01234, 4, 1'b0, 0);
    run_diff(1'b0, 20'h1a000, 5, 1'b0, 0);
    run_diff(1'b0, 20'h00005, 5, 1'b1, 5);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    cmp("diff", 32'h0, dms);
    cmp("negative", 32'h0, neg);
    cmp("nominal", 32'h0, p3);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // testbench
